/* hdl/mic_ctrl.sv */
// Purpose: Interrupt control, wake-up and stack pointer logic of an MCU
// Assumes: Core signals instruction boundaries and stop/wait entry
// Notes:   Registers on classic Wishbone, byte data in bits 7:0
`timescale 1ns/10ps

// Summary of operation
// - Set mask blocks all maskable requests
// - External needs mask clear, enable, sensitivity met
// - External entry stacks, sets mask, vectors 1FFA
// - Sensitivity codes select edge or level mode
// - Sensitivity bits writable only when masked
// - External enable writable when masked, reset set
// - Changing sensitivity clears pending external request
// - Edge latched while disabled stays pending
// - Latch cleared at entry; level mode latches falling edges
// - Any enabled timer flag raises timer request
// - Capture, compare, overflow use separate vectors
// - Timer control holds three enables, two of them shared
// - Any enabled serial flag raises serial request
// - Serial control two holds four enables
// - All serial causes share vector 1FF2
// - Reset sets mask, vectors to 1FFE
// - Stop halts until external request or reset
// - Wait ends on any enabled request
// - Reset or instruction loads pointer 00FF
// - Stack address upper bits fixed, six-bit wrap
// - Interrupt takes five locations, call two
// - Fixed priority from reset down to serial
// - Requests checked only at instruction end
module mic_ctrl
	import mic_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        ext_irq_n_i,
	input  wire logic [4:0]  timer_flags_i,
	input  wire logic [4:0]  serial_flags_i,
	input  wire logic        insn_done_i,
	input  wire logic        trap_i,
	input  wire logic        mask_clear_i,
	input  wire logic        mask_set_i,
	input  wire logic        stop_i,
	input  wire logic        wait_i,
	input  wire logic        stack_op_valid_i,
	input  wire mic_stack_op_t stack_op_i,
	output mic_grant_t       grant_o,
	output logic             mask_o,
	output logic             osc_on_o,
	output logic             cpu_clk_en_o,
	output logic [15:0]      stack_addr_o
);
	typedef enum logic [2:0] {
		MIC_RUN   = 3'b001,
		MIC_STOP  = 3'b010,
		MIC_WAIT  = 3'b100
	} mic_state_t;

	mic_state_t  state;
	mic_state_t  next_state;
	logic [1:0]  pin_sync;
	logic        pin_prev;
	logic        ext_rise_select;
	logic        ext_fall_select;
	logic        ext_irq_enable;
	logic        ext_latch;
	logic        mask;
	logic [7:0]  timer_control;
	logic [7:0]  serial_control_two;
	logic [5:0]  sp;
	logic        ack;
	logic [7:0]  rdata;
	mic_grant_t  grant;
	logic        next_rise;
	logic        next_fall;
	logic        next_en;
	logic        next_latch;
	logic        next_mask;
	logic [7:0]  next_tctl;
	logic [7:0]  next_scc2;
	logic [5:0]  next_sp;
	logic        next_ack;
	logic [7:0]  next_rdata;
	mic_grant_t  next_grant;
	logic        req;
	logic        wr;
	logic        pin_lvl;
	logic        edge_hit;
	logic        level_hit;
	logic        ext_req;
	logic        cap_req;
	logic        cmp_req;
	logic        ovf_req;
	logic        ser_req;
	logic        any_hw;
	logic [4:0]  ser_en;

	default clocking cb_mic @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Pin stage one is read only by stage two
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_sync <= 2'h3;
			pin_prev <= 1'b1;
		end else begin
			pin_sync <= {pin_sync[0], ext_irq_n_i};
			pin_prev <= pin_sync[1];
		end
	end

	always_comb begin
		pin_lvl = pin_sync[1];
		req = wb_cyc_i & wb_stb_i & ~ack;
		wr = req & wb_we_i & wb_sel_i[0];
		// Edge selection per sensitivity code
		edge_hit = (ext_fall_select | ~ext_rise_select) & pin_prev
			& ~pin_lvl;
		if (ext_rise_select & ~pin_prev & pin_lvl) begin
			edge_hit = 1'b1;
		end
		level_hit = ~ext_rise_select & ~ext_fall_select & ~pin_lvl;
		// Level mode also latches the falling edge, so it holds after the pin rises
		ext_req = ~mask & ext_irq_enable & (ext_latch | level_hit);
		cap_req = ~mask & timer_control[MIC_TCTL_CAP]
			& (timer_flags_i[4] | timer_flags_i[3]);
		cmp_req = ~mask & timer_control[MIC_TCTL_CMP]
			& (timer_flags_i[2] | timer_flags_i[1]);
		ovf_req = ~mask & timer_control[MIC_TCTL_OVF]
			& timer_flags_i[0];
		ser_en = {serial_control_two[MIC_SCC2_TXE],
			serial_control_two[MIC_SCC2_TXC],
			serial_control_two[MIC_SCC2_RX],
			serial_control_two[MIC_SCC2_RX],
			serial_control_two[MIC_SCC2_IDLE]};
		ser_req = ~mask & |(serial_flags_i & ser_en);
		any_hw = ext_req | cap_req | cmp_req | ovf_req | ser_req;
	end

	always_comb begin
		next_rise = ext_rise_select;
		next_fall = ext_fall_select;
		next_en = ext_irq_enable;
		next_latch = ext_latch;
		next_mask = mask;
		next_tctl = timer_control;
		next_scc2 = serial_control_two;
		next_sp = sp;
		next_ack = req;
		next_rdata = 8'h00;
		next_grant = '0;
		next_state = state;
		if (mask_clear_i) begin
			next_mask = 1'b0;
		end
		if (mask_set_i) begin
			next_mask = 1'b1;
		end
		if (req) begin
			unique case (wb_adr_i)
			MIC_IDX_MISC: next_rdata = {1'b0, ext_rise_select,
				ext_fall_select, ext_irq_enable, 3'h0, ext_latch};
			MIC_IDX_SCC2: next_rdata = serial_control_two;
			MIC_IDX_SSTAT: next_rdata = {serial_flags_i, 3'h0};
			MIC_IDX_TCTL: next_rdata = timer_control;
			MIC_IDX_TSTAT: next_rdata = {timer_flags_i, 3'h0};
			MIC_IDX_CORE: next_rdata = {state, mask, 2'h0, sp[5:4]};
			default: next_rdata = 8'h00;
			endcase
		end
		if (wr && mask) begin
			if (wb_adr_i == MIC_IDX_MISC) begin
				next_rise = wb_dat_i[MIC_MISC_RISE];
				next_fall = wb_dat_i[MIC_MISC_FALL];
				next_en = wb_dat_i[MIC_MISC_EN];
				if (wb_dat_i[MIC_MISC_RISE] != ext_rise_select ||
					wb_dat_i[MIC_MISC_FALL] != ext_fall_select) begin
					next_latch = 1'b0;
				end
			end
		end
		if (wr && wb_adr_i == MIC_IDX_TCTL) begin
			next_tctl = wb_dat_i[7:0];
		end
		if (wr && wb_adr_i == MIC_IDX_SCC2) begin
			next_scc2 = wb_dat_i[7:0];
		end
		unique case (state)
		MIC_RUN: begin
			if (stop_i) begin
				next_state = MIC_STOP;
				next_mask = 1'b0;
			end else if (wait_i) begin
				next_state = MIC_WAIT;
				next_mask = 1'b0;
			end else if (insn_done_i) begin
				// Priority: trap, external, capture, compare, overflow, serial
				next_grant.take = trap_i | any_hw;
				if (trap_i) begin
					next_grant.vector = MIC_VEC_TRAP;
				end else if (ext_req) begin
					next_grant.vector = MIC_VEC_EXT;
					next_latch = 1'b0;
				end else if (cap_req) begin
					next_grant.vector = MIC_VEC_CAP;
				end else if (cmp_req) begin
					next_grant.vector = MIC_VEC_CMP;
				end else if (ovf_req) begin
					next_grant.vector = MIC_VEC_OVF;
				end else if (ser_req) begin
					next_grant.vector = MIC_VEC_SER;
				end
				if (trap_i | any_hw) begin
					next_mask = 1'b1;
				end
			end
		end
		MIC_STOP: begin
			if (ext_req) begin
				next_state = MIC_RUN;
			end
		end
		MIC_WAIT: begin
			if (any_hw) begin
				next_state = MIC_RUN;
			end
		end
		default: next_state = MIC_RUN;
		endcase
		// Latch edges even while disabled; a new edge beats an option
		// change or an entry clear in the same cycle, so no pulse is lost
		if (edge_hit) begin
			next_latch = 1'b1;
		end
		if (stack_op_valid_i) begin
			if (stack_op_i.sp_reset) begin
				next_sp = MIC_SP_RESET;
			end else if (stack_op_i.push_irq) begin
				next_sp = sp - MIC_STK_IRQ;
			end else if (stack_op_i.push_call) begin
				next_sp = sp - MIC_STK_CALL;
			end else if (stack_op_i.pull_irq) begin
				next_sp = sp + MIC_STK_IRQ;
			end else if (stack_op_i.pull_call) begin
				next_sp = sp + MIC_STK_CALL;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_rise_select <= 1'b0;
			ext_fall_select <= 1'b0;
			ext_irq_enable <= 1'b1;
			ext_latch <= 1'b0;
			mask <= 1'b1;
			timer_control <= 8'h00;
			serial_control_two <= 8'h00;
			sp <= MIC_SP_RESET;
			ack <= 1'b0;
			rdata <= 8'h00;
			grant <= '{take: 1'b1, vector: MIC_VEC_RESET};
			state <= MIC_RUN;
		end else begin
			ext_rise_select <= next_rise;
			ext_fall_select <= next_fall;
			ext_irq_enable <= next_en;
			ext_latch <= next_latch;
			mask <= next_mask;
			timer_control <= next_tctl;
			serial_control_two <= next_scc2;
			sp <= next_sp;
			ack <= next_ack;
			rdata <= next_rdata;
			grant <= next_grant;
			state <= next_state;
		end
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = {24'h000000, rdata};
	assign grant_o = grant;
	assign mask_o = mask;
	assign osc_on_o = (state != MIC_STOP);
	assign cpu_clk_en_o = (state == MIC_RUN);
	assign stack_addr_o = {MIC_SP_UPPER, sp};

	a_mask_blocks: assert property (mask |->
		!(ext_req | cap_req | cmp_req | ovf_req | ser_req))
		else $error("request while masked");
	a_mask_no_grant: assert property (mask && !trap_i |=>
		!grant.take)
		else $error("grant while masked");
	a_ext_vector: assert property (state == MIC_RUN
		&& insn_done_i && !stop_i && !wait_i && !trap_i && ext_req
		|=> grant.take && grant.vector == MIC_VEC_EXT && mask)
		else $error("external vector wrong");
	a_opt_locked: assert property (!mask && !mask_set_i |=>
		$stable(ext_rise_select) && $stable(ext_fall_select))
		else $error("option changed unmasked");
	a_en_locked: assert property (!mask && !mask_set_i |=>
		$stable(ext_irq_enable))
		else $error("enable changed unmasked");
	a_opt_clears: assert property (
		(ext_rise_select != $past(ext_rise_select)
		|| ext_fall_select != $past(ext_fall_select))
		&& !$past(edge_hit) |-> !ext_latch)
		else $error("latch kept over option change");
	a_stack_range: assert property (
		stack_addr_o[15:6] == MIC_SP_UPPER)
		else $error("stack outside page");
	a_irq_push: assert property (stack_op_valid_i
		&& stack_op_i == 5'b10000 |=> sp == $past(sp) - MIC_STK_IRQ)
		else $error("interrupt push not five");

	// Low power states
	a_stop_wake: assert property (state == MIC_STOP && !ext_req
		|=> state == MIC_STOP)
		else $error("stop left without external");
	a_stop_exit: assert property (state == MIC_STOP && ext_req
		|=> state == MIC_RUN)
		else $error("stop kept after external");
	a_wait_hold: assert property (state == MIC_WAIT && !any_hw
		|=> state == MIC_WAIT)
		else $error("wait left without request");
	a_wait_exit: assert property (state == MIC_WAIT && any_hw
		|=> state == MIC_RUN)
		else $error("wait kept after request");

	// Grant timing and priority
	a_grant_boundary: assert property (!insn_done_i |=>
		!grant.take)
		else $error("grant between instructions");
	a_grant_masks: assert property (grant.take |-> mask)
		else $error("grant left mask clear");
	a_trap_first: assert property (state == MIC_RUN
		&& insn_done_i && trap_i && !stop_i && !wait_i
		|=> grant.take && grant.vector == MIC_VEC_TRAP)
		else $error("trap not first");
	a_cap_order: assert property (state == MIC_RUN
		&& insn_done_i && !stop_i && !wait_i && !trap_i && !ext_req
		&& cap_req |=> grant.take && grant.vector == MIC_VEC_CAP)
		else $error("capture not before other timer");
	a_ser_vector: assert property (state == MIC_RUN
		&& insn_done_i && !stop_i && !wait_i && !trap_i && !ext_req
		&& !cap_req && !cmp_req && !ovf_req && ser_req
		|=> grant.take && grant.vector == MIC_VEC_SER)
		else $error("serial vector wrong");

	// External latch
	a_ext_latch_clr: assert property (state == MIC_RUN
		&& insn_done_i && !stop_i && !wait_i && !trap_i && ext_req
		&& !edge_hit |=> !ext_latch)
		else $error("latch kept after entry");
	a_edge_latches: assert property (edge_hit |=> ext_latch)
		else $error("edge not latched");
	a_level_unlatched: assert property (!edge_hit && !ext_latch |=>
		!ext_latch)
		else $error("latch set without edge");

	c_ext_taken: cover property (
		grant.take && grant.vector == MIC_VEC_EXT);
	c_wait_wake: cover property (
		state == MIC_WAIT ##1 state == MIC_RUN);
	c_ser_taken: cover property (
		grant.take && grant.vector == MIC_VEC_SER);
	c_trap_taken: cover property (
		grant.take && grant.vector == MIC_VEC_TRAP);
	c_stop_wake: cover property (
		state == MIC_STOP ##1 state == MIC_RUN);
endmodule : mic_ctrl

/* hdl/mic_pkg.sv */
// Purpose: Shared constants and types of the interrupt control block
// Assumes: Byte-wide registers, one per aligned 32-bit Wishbone word
// Notes:   Offsets are register indices; byte address is four times
package mic_pkg;
	localparam logic [7:0]  MIC_IDX_MISC    = 8'h0C;
	localparam logic [7:0]  MIC_IDX_SCC2    = 8'h0F;
	localparam logic [7:0]  MIC_IDX_SSTAT   = 8'h10;
	localparam logic [7:0]  MIC_IDX_TCTL    = 8'h12;
	localparam logic [7:0]  MIC_IDX_TSTAT   = 8'h13;
	localparam logic [7:0]  MIC_IDX_CORE    = 8'h20;
	localparam int          MIC_MISC_RISE   = 6;
	localparam int          MIC_MISC_FALL   = 5;
	localparam int          MIC_MISC_EN     = 4;
	localparam int          MIC_TCTL_CAP    = 7;
	localparam int          MIC_TCTL_CMP    = 6;
	localparam int          MIC_TCTL_OVF    = 5;
	localparam int          MIC_SCC2_TXE    = 7;
	localparam int          MIC_SCC2_TXC    = 6;
	localparam int          MIC_SCC2_RX     = 5;
	localparam int          MIC_SCC2_IDLE   = 4;
	localparam logic [15:0] MIC_VEC_RESET   = 16'h1FFE;
	localparam logic [15:0] MIC_VEC_TRAP    = 16'h1FFC;
	localparam logic [15:0] MIC_VEC_EXT     = 16'h1FFA;
	localparam logic [15:0] MIC_VEC_CAP     = 16'h1FF8;
	localparam logic [15:0] MIC_VEC_CMP     = 16'h1FF6;
	localparam logic [15:0] MIC_VEC_OVF     = 16'h1FF4;
	localparam logic [15:0] MIC_VEC_SER     = 16'h1FF2;
	localparam logic [5:0]  MIC_SP_RESET    = 6'h3F;
	localparam logic [9:0]  MIC_SP_UPPER    = 10'h003;
	localparam logic [5:0]  MIC_STK_IRQ     = 6'h05;
	localparam logic [5:0]  MIC_STK_CALL    = 6'h02;
	localparam logic [7:0]  MIC_MISC_RST    = 8'h10;
	localparam logic [7:0]  MIC_SSTAT_RST   = 8'hC0;

	typedef struct packed {
		logic        take;
		logic [15:0] vector;
	} mic_grant_t;

	typedef struct packed {
		logic       push_irq;
		logic       push_call;
		logic       pull_irq;
		logic       pull_call;
		logic       sp_reset;
	} mic_stack_op_t;
endpackage : mic_pkg

/* sim/mic_core_model.sv */
// Purpose: Core sequencer stand-in for the interrupt control bench
// Assumes: One instruction ends every fourth cycle while clocked
// Notes:   Pushes an interrupt frame one cycle after each grant but the reset vector
`timescale 1ns/10ps
module mic_core_model
	import mic_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       clk_en_i,
	input  wire mic_grant_t grant_i,
	output logic            insn_done_o,
	output logic            stack_op_valid_o,
	output mic_stack_op_t   stack_op_o
);
	logic [1:0] cnt   = 2'h0;
	logic       rst_d = 1'b1;
	assign stack_op_o = '{push_irq: 1'b1, default: 1'b0};
	always @(posedge clk_i) begin
		rst_d <= rst_i;
		cnt <= rst_i ? 2'h0 : cnt + 2'h1;
		// A halted core ends no instruction
		insn_done_o <= !rst_i && clk_en_i && cnt == 2'h3;
		// Reset vector is no entry, so no frame
		stack_op_valid_o <= !rst_d && grant_i.take;
	end
endmodule : mic_core_model

/* sim/mic_ctrl_tb.sv */
// Purpose: Self-checking bench of the interrupt control block
// Assumes: Core stand-in ends an instruction every fourth cycle
// Notes:   Random timer and serial mixes; pin cases by hand
`timescale 1ns/10ps
module mic_ctrl_tb
	import mic_pkg::*;
;
	logic          clk_i = 1'b0;
	logic          rst_i = 1'b1;
	logic          cyc = 1'b0, stb = 1'b0, we = 1'b0, ext = 1'b1;
	logic [7:0]    adr = 8'h00, q;
	logic [31:0]   dat = 32'h0, dat_o;
	logic [3:0]    pu = 4'h0, se;
	logic [4:0]    tf = 5'h00, sf = 5'h00, rt, rs;
	logic [2:0]    te;
	logic [15:0]   sa, ev;
	logic          ack, mask, osc, clk_en, done, opv, rst_d = 1'b1;
	logic          trap = 1'b0;
	mic_grant_t    gr;
	mic_stack_op_t op;
	int            fail_count = 0, checked = 0, cyc_n = 0, ng = 0;
	int            seed = 32'h716e;
	mic_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
		.wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.ext_irq_n_i(ext), .timer_flags_i(tf), .serial_flags_i(sf),
		.insn_done_i(done), .trap_i(trap), .mask_clear_i(pu[0]),
		.mask_set_i(pu[1]), .stop_i(pu[2]), .wait_i(pu[3]),
		.stack_op_valid_i(opv), .stack_op_i(op), .grant_o(gr),
		.mask_o(mask), .osc_on_o(osc), .cpu_clk_en_o(clk_en),
		.stack_addr_o(sa));
	mic_core_model core (.clk_i(clk_i), .rst_i(rst_i), .clk_en_i(clk_en),
		.grant_i(gr), .insn_done_o(done), .stack_op_valid_o(opv),
		.stack_op_o(op));
	initial forever #2 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		rst_d <= rst_i;
		cyc_n <= cyc_n + 1;
		if (!rst_d && gr.take === 1'b1) ng <= ng + 1;
		// Whole run needs about a thousand cycles
		if (cyc_n == 30000) begin
			fail_count = fail_count + 1;
			finish_test();
		end
	end
	task finish_test();
		if (fail_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test
	task chk(input logic [16:0] g, input logic [16:0] e);
		checked = checked + 1;
		if (g !== e) begin
			fail_count = fail_count + 1;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		q = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, d);
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk({9'h0, q}, {9'h0, e});
	endtask : rd
	task pl(input logic [3:0] m);
		@(posedge clk_i);
		pu <= m;
		@(posedge clk_i);
		pu <= 4'h0;
	endtask : pl
	task pin(input logic v);
		@(posedge clk_i);
		ext <= v;
		repeat (6) @(posedge clk_i);
	endtask : pin
	task tk(input logic [15:0] v);
		for (int i = 0; i < 80 && gr.take !== 1'b1; i++) @(posedge clk_i);
		chk(gr, {1'b1, v});
		chk({16'h0, mask}, 17'h1);
		@(posedge clk_i);
	endtask : tk
	task none(input int n);
		repeat (n) begin
			@(posedge clk_i);
			chk({16'h0, gr.take}, 17'h0);
		end
	endtask : none
	function automatic logic [15:0] vec(input logic [4:0] t, s,
		input logic [2:0] e, input logic [3:0] c);
		if (|t[4:3] && e[2]) return MIC_VEC_CAP;
		if (|t[2:1] && e[1]) return MIC_VEC_CMP;
		if (t[0] && e[0]) return MIC_VEC_OVF;
		// Overrun and receive-full share one enable
		if (|(s & {c[3:1], c[1], c[0]})) return MIC_VEC_SER;
		return 16'h0;
	endfunction : vec
	initial begin
		repeat (4) @(posedge clk_i);
		chk(gr, {1'b1, MIC_VEC_RESET});
		chk({mask, sa}, {1'b1, 16'h00FF});
		@(posedge clk_i);
		rst_i <= 1'b0;
		rd(MIC_IDX_MISC, 8'h10);
		rd(8'h05, 8'h00);
		wr(MIC_IDX_MISC, 8'h20);
		pin(1'b0);
		pin(1'b1);
		rd(MIC_IDX_MISC, 8'h21);
		pl(4'h1);
		none(20);
		wr(MIC_IDX_MISC, 8'h30);
		rd(MIC_IDX_MISC, 8'h21);
		pl(4'h2);
		wr(MIC_IDX_MISC, 8'h30);
		pl(4'h1);
		tk(MIC_VEC_EXT);
		rd(MIC_IDX_MISC, 8'h30);
		pin(1'b0);
		wr(MIC_IDX_MISC, 8'h50);
		rd(MIC_IDX_MISC, 8'h50);
		pin(1'b1);
		rd(MIC_IDX_MISC, 8'h51);
		wr(MIC_IDX_MISC, 8'h70);
		pin(1'b0);
		rd(MIC_IDX_MISC, 8'h71);
		wr(MIC_IDX_MISC, 8'h10);
		rd(MIC_IDX_MISC, 8'h10);
		pl(4'h1);
		tk(MIC_VEC_EXT);
		trap <= 1'b1;
		tk(MIC_VEC_TRAP);
		trap <= 1'b0;
		pin(1'b1);
		wr(MIC_IDX_MISC, 8'h30);
		wr(MIC_IDX_TCTL, 8'hE0);
		tf <= 5'h08;
		pin(1'b0);
		pl(4'h1);
		tk(MIC_VEC_EXT);
		pl(4'h1);
		tk(MIC_VEC_CAP);
		pin(1'b1);
		pl(4'h4);
		repeat (12) @(posedge clk_i);
		chk({15'h0, osc, clk_en}, 17'h0);
		pin(1'b0);
		tk(MIC_VEC_EXT);
		chk({15'h0, osc, clk_en}, 17'h3);
		tf <= 5'h00;
		wr(MIC_IDX_SCC2, 8'h80);
		pl(4'h8);
		repeat (8) @(posedge clk_i);
		chk({15'h0, osc, clk_en}, 17'h2);
		sf <= 5'h10;
		tk(MIC_VEC_SER);
		sf <= 5'h00;
		pin(1'b1);
		repeat (24) begin
			te = $random(seed);
			se = $random(seed);
			rt = $random(seed);
			rs = $random(seed);
			wr(MIC_IDX_TCTL, {te, 5'h00});
			wr(MIC_IDX_SCC2, {se, 4'h0});
			tf <= rt;
			sf <= rs;
			none(8);
			rd(MIC_IDX_TSTAT, {rt, 3'h0});
			rd(MIC_IDX_SSTAT, {rs, 3'h0});
			ev = vec(rt, rs, te, se);
			pl(4'h1);
			if (ev !== 16'h0) tk(ev);
			else none(12);
			tf <= 5'h00;
			sf <= 5'h00;
			pl(4'h2);
		end
		repeat (4) @(posedge clk_i);
		chk({1'b0, sa}, {1'b0, MIC_SP_UPPER, 6'(63 - 5 * ng)});
		finish_test();
	end
endmodule : mic_ctrl_tb
